// File: rtl/spm_pkg.sv
// Constants, register map and types of the self-programming sequencer
package spm_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ            = 50000000;
  localparam int unsigned PROG_TIME_US      = 3700;
  localparam int unsigned PROG_CYCLES       = PROG_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned TIMER_W           = 18;
  localparam logic [2:0]  CMD_WINDOW_CYCLES = 3'h4;

  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h37;
  localparam logic [7:0] IDX_Z_POINTER   = 8'h38;
  localparam logic [7:0] IDX_DATA_WORD   = 8'h39;
  localparam logic [7:0] IDX_SPM_STROBE  = 8'h3a;
  localparam logic [7:0] IDX_CONFIG      = 8'h3b;
  localparam logic [7:0] IDX_BOOT_INFO   = 8'h3c;
  localparam logic [7:0] IDX_Z_INFO      = 8'h3d;
  localparam logic [7:0] IDX_BUF_DATA    = 8'h3e;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h3f;
  localparam logic [7:0] IDX_IRQ_CLEAR   = 8'h40;
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h41;

  // ==========================================================================
  // Control/status bit positions and reset value
  localparam int unsigned BIT_PROGRAM_ENABLE = 0;
  localparam int unsigned BIT_PAGE_ERASE     = 1;
  localparam int unsigned BIT_PAGE_WRITE     = 2;
  localparam int unsigned BIT_LOCK_BIT_SET   = 3;
  localparam int unsigned BIT_REENABLE       = 4;
  localparam int unsigned BIT_SIGNATURE_READ = 5;
  localparam int unsigned BIT_REGION_BUSY    = 6;
  localparam int unsigned BIT_IRQ_ENABLE     = 7;
  localparam int unsigned BIT_SPM_STROBE     = 0;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;

  // ==========================================================================
  // Events
  localparam int unsigned EV_DONE    = 0;
  localparam int unsigned EV_EXPIRED = 1;
  localparam int unsigned EV_REFUSED = 2;
  localparam int unsigned EV_W       = 3;

  // ==========================================================================
  // Boot section starts and sizes in words, fuse pair hi:lo as index
  localparam logic [15:0] BOOT13_START_11 = 16'h1f80;
  localparam logic [15:0] BOOT13_START_10 = 16'h1f00;
  localparam logic [15:0] BOOT13_START_01 = 16'h1e00;
  localparam logic [15:0] BOOT13_START_00 = 16'h1c00;
  localparam logic [15:0] BOOT14_START_11 = 16'h3f00;
  localparam logic [15:0] BOOT14_START_10 = 16'h3e00;
  localparam logic [15:0] BOOT14_START_01 = 16'h3c00;
  localparam logic [15:0] BOOT14_START_00 = 16'h3800;
  localparam logic [15:0] BOOT_WORDS_128  = 16'h0080;
  localparam logic [15:0] BOOT_WORDS_256  = 16'h0100;
  localparam logic [15:0] BOOT_WORDS_512  = 16'h0200;
  localparam logic [15:0] BOOT_WORDS_1024 = 16'h0400;
  localparam logic [15:0] BOOT_WORDS_2048 = 16'h0800;

  // ==========================================================================
  // Read-while-write limits and pointer layout
  localparam logic [15:0] RWW_END13   = 16'h1bff;
  localparam logic [15:0] RWW_END14   = 16'h37ff;
  localparam int unsigned WORD_IDX_W  = 6;
  localparam int unsigned PAGE_WORDS  = 64;
  localparam int unsigned DATA_W      = 16;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY  = 2'b10
  } seq_state_type;

endpackage

// File: rtl/page_buffer_mem.sv
// Temporary page buffer with registered read data
module page_buffer_mem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = 6
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// File: rtl/self_program_ctrl.sv
// Boot section decoder and self-programming command sequencer, AHB-Lite slave
//
// The AHB-Lite register port and the address map are this design's own decisions.

// Contract
// - 13-bit counter: fuse pair picks boot size 128..1024 words, start 0x1F80..0x1C00
// - 14-bit counter: fuse pair picks boot size 256..2048 words, start 0x3F00..0x3800
// - Readable region ends 0x1BFF or 0x37FF; higher words are the halting region
// - During page erase or write, fetches allowed only from the halting region
// - Pointer bit 0 must be zero for commands; it selects byte on loads
// - 13-bit counter: page from PC[12:6], word index from pointer bits 6..1
// - 14-bit counter: page from PC[13:6], counter top bit on pointer bit 14
// - Busy flag stays set until re-enable or a buffer fill, each with program enable, clears it
// - Page update: erase, re-enable, fill buffer, write page, re-enable
// - Fill with only program enable loads data word at pointer word index
// - 8-bit control/status register, all zero after reset, busy flag read-only
// - Command bits take effect only if a store follows within four cycles, except the re-enable bit's abort of a buffer load, done on the write
// - Busy flag set by readable-region erase or write, cleared by re-enable or fill
// - Re-enable aborts a buffer load; refused while erase or write runs
module self_program_ctrl #(
  parameter int unsigned PROG_CYCLES = spm_pkg::PROG_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] HRDATA,
  input  wire logic        BOOT_SIZE_FUSE_HI,
  input  wire logic        BOOT_SIZE_FUSE_LO,
  input  wire logic        EEPROM_WRITE_BUSY,
  input  wire logic [15:0] FETCH_ADDR,
  output logic             FETCH_ALLOW,
  output logic             CPU_HALT,
  output logic             REGION_BUSY_FLAG,
  output logic             FLASH_ERASE_START,
  output logic             FLASH_WRITE_START,
  output logic             LOCK_WRITE_START,
  output logic      [7:0]  FLASH_PAGE,
  output logic      [7:0]  LOCK_DATA,
  output logic      [15:0] BOOT_RESET_ADDR,
  output logic             IRQ
);

  // ==========================================================================
  // Decode helpers
  function automatic logic in_halting(input logic [15:0] a, input logic v14);
    in_halting = v14 ? (a > spm_pkg::RWW_END14) : (a > spm_pkg::RWW_END13);
  endfunction

  function automatic logic [15:0] boot_start(input logic [1:0] f,
                                             input logic v14);
    case (f)
      2'b11:   boot_start = v14 ? spm_pkg::BOOT14_START_11
                                : spm_pkg::BOOT13_START_11;
      2'b10:   boot_start = v14 ? spm_pkg::BOOT14_START_10
                                : spm_pkg::BOOT13_START_10;
      2'b01:   boot_start = v14 ? spm_pkg::BOOT14_START_01
                                : spm_pkg::BOOT13_START_01;
      default: boot_start = v14 ? spm_pkg::BOOT14_START_00
                                : spm_pkg::BOOT13_START_00;
    endcase
  endfunction

  function automatic logic [15:0] boot_words(input logic [1:0] f,
                                             input logic v14);
    case (f)
      2'b11:   boot_words = v14 ? spm_pkg::BOOT_WORDS_256
                                : spm_pkg::BOOT_WORDS_128;
      2'b10:   boot_words = v14 ? spm_pkg::BOOT_WORDS_512
                                : spm_pkg::BOOT_WORDS_256;
      2'b01:   boot_words = v14 ? spm_pkg::BOOT_WORDS_1024
                                : spm_pkg::BOOT_WORDS_512;
      default: boot_words = v14 ? spm_pkg::BOOT_WORDS_2048
                                : spm_pkg::BOOT_WORDS_1024;
    endcase
  endfunction

  // ==========================================================================
  // State
  spm_pkg::seq_state_type state_r, state_nxt;
  logic [1:0]                  fuse_s1_r, fuse_s2_r;
  logic                        wr_pend_r, rd_pend_r;
  logic [7:0]                  wr_idx_r, rd_idx_r;
  logic [5:0]                  cmd_r, cmd_nxt;
  logic                        program_ready_irq_enable_r, v14_r;
  logic                        rww_busy_r, rww_busy_nxt;
  logic                        loaded_r, loaded_nxt;
  logic                        op_rww_r, op_rww_nxt;
  logic                        page_op_r, page_op_nxt;
  logic [2:0]                  win_r, win_nxt;
  logic [spm_pkg::TIMER_W-1:0] timer_r, timer_nxt;
  logic [15:0]                 z_r, data_r;
  logic [spm_pkg::EV_W-1:0]    ev_r, ev_en_r, ev_set;
  logic [15:0]                 buf_rd;
  logic                        fill_we, erase_go, write_go, lock_go;

  // ==========================================================================
  // Bus decode
  wire       addr_phase = HSEL & HREADY & HTRANS[1];
  wire [7:0] a_idx      = HADDR[9:2];
  wire       a_ok       = (HADDR[31:10] == 22'h000000) &
                          (HADDR[1:0] == 2'h0) & (HSIZE == 3'h2);
  wire       wr_csr     = wr_pend_r & (wr_idx_r == spm_pkg::IDX_CTRL_STATUS);
  wire       wr_z       = wr_pend_r & (wr_idx_r == spm_pkg::IDX_Z_POINTER);
  wire       wr_data    = wr_pend_r & (wr_idx_r == spm_pkg::IDX_DATA_WORD);
  wire       wr_strobe  = wr_pend_r & (wr_idx_r == spm_pkg::IDX_SPM_STROBE);
  wire       wr_cfg     = wr_pend_r & (wr_idx_r == spm_pkg::IDX_CONFIG);
  wire       wr_clr     = wr_pend_r & (wr_idx_r == spm_pkg::IDX_IRQ_CLEAR);
  wire       wr_en      = wr_pend_r & (wr_idx_r == spm_pkg::IDX_IRQ_ENABLE);

  // ==========================================================================
  // Address decode of pointer and fetch
  wire [1:0]  fuse_w      = fuse_s2_r;
  wire [7:0]  z_page      = v14_r ? z_r[14:7] : {1'b0, z_r[13:7]};
  wire [5:0]  z_word      = z_r[6:1];
  wire [15:0] page_base   = {2'b00, z_page, 6'h00};
  wire        page_rww    = ~in_halting(page_base, v14_r);
  wire        fetch_halt  = in_halting(FETCH_ADDR, v14_r);
  wire [15:0] boot_start_w = boot_start(fuse_w, v14_r);
  wire [15:0] boot_words_w = boot_words(fuse_w, v14_r);
  wire        busy_w      = (state_r == spm_pkg::ST_BUSY);
  wire        armed_w     = (state_r == spm_pkg::ST_ARMED);
  wire        spm_take    = armed_w & wr_strobe & HWDATA[spm_pkg::BIT_SPM_STROBE];
  wire        csr_cmd_wr  = wr_csr & ~busy_w;
  wire        fill_cmd    = (cmd_r == 6'h01);

  wire [7:0]  csr_val = {program_ready_irq_enable_r, rww_busy_r, cmd_r};
  wire [31:0] rd_val =
    (rd_idx_r == spm_pkg::IDX_CTRL_STATUS) ? {24'h000000, csr_val} :
    (rd_idx_r == spm_pkg::IDX_Z_POINTER)   ? {16'h0000, z_r} :
    (rd_idx_r == spm_pkg::IDX_DATA_WORD)   ? {16'h0000, data_r} :
    (rd_idx_r == spm_pkg::IDX_CONFIG)      ? {31'h00000000, v14_r} :
    (rd_idx_r == spm_pkg::IDX_BOOT_INFO)   ? {boot_words_w, boot_start_w} :
    (rd_idx_r == spm_pkg::IDX_Z_INFO)      ? {loaded_r, page_rww, z_word,
                                              z_page, page_base} :
    (rd_idx_r == spm_pkg::IDX_BUF_DATA)    ? {16'h0000, buf_rd} :
    (rd_idx_r == spm_pkg::IDX_IRQ_STATUS)  ? {29'h00000000, ev_r} :
    (rd_idx_r == spm_pkg::IDX_IRQ_ENABLE)  ? {29'h00000000, ev_en_r} :
                                             32'h00000000;

  // ==========================================================================
  // Command sequencer
  always_comb begin
    state_nxt    = state_r;
    cmd_nxt      = cmd_r;
    win_nxt      = win_r;
    timer_nxt    = timer_r;
    rww_busy_nxt = rww_busy_r;
    loaded_nxt   = loaded_r;
    op_rww_nxt   = op_rww_r;
    page_op_nxt  = page_op_r;
    fill_we      = 1'b0;
    erase_go     = 1'b0;
    write_go     = 1'b0;
    lock_go      = 1'b0;
    ev_set       = '0;
    case (state_r)
      spm_pkg::ST_IDLE, spm_pkg::ST_ARMED: begin
        if (spm_take) begin
          state_nxt = spm_pkg::ST_IDLE;
          cmd_nxt   = 6'h00;
          if (z_r[0] | EEPROM_WRITE_BUSY) begin
            ev_set[spm_pkg::EV_REFUSED] = 1'b1;
          end else if (cmd_r[spm_pkg::BIT_SIGNATURE_READ]) begin
            ev_set[spm_pkg::EV_DONE] = 1'b1;
          end else if (cmd_r[spm_pkg::BIT_REENABLE]) begin
            rww_busy_nxt = 1'b0;
            loaded_nxt   = 1'b0;
            ev_set[spm_pkg::EV_DONE] = 1'b1;
          end else if (cmd_r[spm_pkg::BIT_LOCK_BIT_SET] |
                       cmd_r[spm_pkg::BIT_PAGE_WRITE] |
                       cmd_r[spm_pkg::BIT_PAGE_ERASE]) begin
            state_nxt   = spm_pkg::ST_BUSY;
            cmd_nxt     = cmd_r;
            timer_nxt   = spm_pkg::TIMER_W'(PROG_CYCLES - 1);
            lock_go     = cmd_r[spm_pkg::BIT_LOCK_BIT_SET];
            page_op_nxt = ~lock_go;
            write_go    = ~lock_go & cmd_r[spm_pkg::BIT_PAGE_WRITE];
            erase_go    = ~lock_go & ~write_go;
            op_rww_nxt  = ~lock_go & page_rww;
            if (~lock_go & page_rww) begin
              rww_busy_nxt = 1'b1;
            end
          end else begin
            fill_we      = fill_cmd;
            loaded_nxt   = 1'b1;
            rww_busy_nxt = 1'b0;
            ev_set[spm_pkg::EV_DONE] = 1'b1;
          end
        end else if (csr_cmd_wr) begin
          cmd_nxt = HWDATA[5:0];
          win_nxt = 3'h0;
          if (HWDATA[spm_pkg::BIT_REENABLE]) begin
            loaded_nxt = 1'b0;
          end
          state_nxt = HWDATA[spm_pkg::BIT_PROGRAM_ENABLE] ? spm_pkg::ST_ARMED
                                                          : spm_pkg::ST_IDLE;
        end else if (armed_w) begin
          if (win_r == spm_pkg::CMD_WINDOW_CYCLES - 3'h1) begin
            state_nxt = spm_pkg::ST_IDLE;
            cmd_nxt   = 6'h00;
            ev_set[spm_pkg::EV_EXPIRED] = 1'b1;
          end else begin
            win_nxt = win_r + 3'h1;
          end
        end
      end
      spm_pkg::ST_BUSY: begin
        if (timer_r == '0) begin
          state_nxt   = spm_pkg::ST_IDLE;
          cmd_nxt     = 6'h00;
          page_op_nxt = 1'b0;
          if (cmd_r[spm_pkg::BIT_PAGE_WRITE]) begin
            loaded_nxt = 1'b0;
          end
          ev_set[spm_pkg::EV_DONE] = 1'b1;
        end else begin
          timer_nxt = timer_r - 1'b1;
        end
      end
      default: begin
        state_nxt = spm_pkg::ST_IDLE;
        cmd_nxt   = 6'h00;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLK) begin
    fuse_s1_r <= {BOOT_SIZE_FUSE_HI, BOOT_SIZE_FUSE_LO};
    fuse_s2_r <= fuse_s1_r;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r    <= spm_pkg::ST_IDLE;
      cmd_r      <= spm_pkg::CTRL_RESET[5:0];
      program_ready_irq_enable_r    <= spm_pkg::CTRL_RESET[spm_pkg::BIT_IRQ_ENABLE];
      rww_busy_r <= spm_pkg::CTRL_RESET[spm_pkg::BIT_REGION_BUSY];
      win_r      <= 3'h0;
      timer_r    <= '0;
      loaded_r   <= 1'b0;
      op_rww_r   <= 1'b0;
      page_op_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cmd_r      <= cmd_nxt;
      rww_busy_r <= rww_busy_nxt;
      win_r      <= win_nxt;
      timer_r    <= timer_nxt;
      loaded_r   <= loaded_nxt;
      op_rww_r   <= op_rww_nxt;
      page_op_r  <= page_op_nxt;
      if (wr_csr) begin
        program_ready_irq_enable_r <= HWDATA[spm_pkg::BIT_IRQ_ENABLE];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      rd_idx_r  <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h00000000;
      z_r       <= 16'h0000;
      data_r    <= 16'h0000;
      v14_r     <= 1'b0;
      ev_r      <= '0;
      ev_en_r   <= '0;
    end else begin
      wr_pend_r <= addr_phase & HWRITE & a_ok;
      rd_pend_r <= addr_phase & ~HWRITE;
      wr_idx_r  <= a_idx;
      rd_idx_r  <= a_ok ? a_idx : 8'h00;
      HREADYOUT <= ~(addr_phase & ~HWRITE);
      HRDATA    <= rd_pend_r ? rd_val : 32'h00000000;
      if (wr_z) z_r <= HWDATA[15:0];
      if (wr_data) data_r <= HWDATA[15:0];
      if (wr_cfg) v14_r <= HWDATA[0];
      if (wr_en) ev_en_r <= HWDATA[spm_pkg::EV_W-1:0];
      // Set wins over a clear in the same cycle
      ev_r <= (ev_r & ~(wr_clr ? HWDATA[spm_pkg::EV_W-1:0] : '0)) | ev_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      FETCH_ALLOW       <= 1'b1;
      CPU_HALT          <= 1'b0;
      REGION_BUSY_FLAG  <= 1'b0;
      FLASH_ERASE_START <= 1'b0;
      FLASH_WRITE_START <= 1'b0;
      LOCK_WRITE_START  <= 1'b0;
      FLASH_PAGE        <= 8'h00;
      LOCK_DATA         <= 8'h00;
      BOOT_RESET_ADDR   <= 16'h0000;
      IRQ               <= 1'b0;
    end else begin
      FETCH_ALLOW       <= ~(busy_w & page_op_r) | fetch_halt;
      CPU_HALT          <= busy_w & page_op_r & ~op_rww_r;
      REGION_BUSY_FLAG  <= rww_busy_r;
      FLASH_ERASE_START <= erase_go;
      FLASH_WRITE_START <= write_go;
      LOCK_WRITE_START  <= lock_go;
      if (erase_go | write_go) FLASH_PAGE <= z_page;
      if (lock_go) LOCK_DATA <= data_r[7:0];
      BOOT_RESET_ADDR   <= boot_start_w;
      // Ready interrupt stays high while idle; software gates it
      IRQ <= (|(ev_r & ev_en_r)) | (program_ready_irq_enable_r & ~cmd_r[0]);
    end
  end

  page_buffer_mem #(
    .WIDTH (spm_pkg::DATA_W),
    .DEPTH (spm_pkg::PAGE_WORDS),
    .AW    (spm_pkg::WORD_IDX_W)
  ) u_buf (
    .clk     (CLK),
    .wr_en   (fill_we),
    .wr_addr (z_word),
    .wr_data (data_r),
    .rd_addr (z_word),
    .rd_data (buf_rd)
  );

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_BOOT13: assert property (!v14_r && fuse_w == 2'b11 && $stable(fuse_w)
    |=> BOOT_RESET_ADDR == 16'h1f80) else $error("boot start 13 wrong");
  AST_BOOT14: assert property (v14_r && fuse_w == 2'b00 && $stable(v14_r)
    |=> BOOT_RESET_ADDR == 16'h3800) else $error("boot start 14 wrong");
  AST_RWW_LIMIT: assert property (!v14_r && FETCH_ADDR == 16'h1c00
    |-> fetch_halt) else $error("halting region limit wrong");
  AST_FETCH_BLOCK: assert property (busy_w && page_op_r && !fetch_halt
    |=> !FETCH_ALLOW) else $error("fetch allowed during page op");
  AST_Z0_REFUSED: assert property (spm_take && z_r[0]
    |=> state_r == spm_pkg::ST_IDLE && ev_r[spm_pkg::EV_REFUSED])
    else $error("odd pointer not refused");
  AST_PAGE13: assert property (erase_go && !v14_r
    |=> FLASH_PAGE == {1'b0, $past(z_r[13:7])}) else $error("page 13 wrong");
  AST_PAGE14: assert property (write_go && v14_r
    |=> FLASH_PAGE == $past(z_r[14:7])) else $error("page 14 wrong");
  AST_EEPROM: assert property (spm_take && EEPROM_WRITE_BUSY
    |=> !busy_w && !FLASH_ERASE_START) else $error("started over EEPROM");
  AST_DONE: assert property (busy_w && timer_r == '0
    |=> state_r == spm_pkg::ST_IDLE && !cmd_r[0]) else $error("no finish");
  AST_FILL: assert property (spm_take && fill_cmd && !z_r[0]
    && !EEPROM_WRITE_BUSY |=> !rww_busy_r ##1 !REGION_BUSY_FLAG)
    else $error("fill kept busy flag");
  AST_RESET_CSR: assert property ($past(RESET) |-> csr_val == 8'h00)
    else $error("control not zero after reset");
  AST_WINDOW: assert property ($rose(armed_w) |-> ##[1:5] !armed_w)
    else $error("command window too long");
  AST_BUSY_SET: assert property ((erase_go || write_go) && page_rww
    |=> rww_busy_r [*2]) else $error("busy flag not set");
  AST_REEN_REFUSED: assert property (busy_w && rww_busy_r
    |=> rww_busy_r) else $error("re-enable during busy");

  COV_ERASE: cover property (erase_go ##[1:8] FLASH_ERASE_START);
  COV_FILL: cover property (fill_we);
  COV_EXPIRE: cover property (ev_set[spm_pkg::EV_EXPIRED]);
  COV_REENABLE: cover property (rww_busy_r ##1 !rww_busy_r);

endmodule

// File: test/cpu_core_model.sv
// Bus-master model of the CPU core running the boot loader
module cpu_core_model (
  input  wire logic        clk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  input  wire logic        ee_busy,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Single word transfers, entered just after a rising edge
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Store follows the control write with no gap: the window is short
  task automatic spm(input logic [7:0] c);
    logic [31:0] q;
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      bus(1'b0, ad(spm_pkg::IDX_CTRL_STATUS), 32'h0, q);
    end
    while (ee_busy !== 1'b0) @(posedge clk);
    bus(1'b1, ad(spm_pkg::IDX_CTRL_STATUS), {24'h0, c}, q);
    bus(1'b1, ad(spm_pkg::IDX_SPM_STROBE), 32'h1, q);
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench of the self-programming sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        fz_hi = 1'b1;
  logic        fz_lo = 1'b1;
  logic        ee_busy = 1'b0;
  logic [15:0] fetch = 16'h1c00;
  logic        hwrite, hready, allow, halt, busy, irq;
  logic [1:0]  htrans;
  logic [7:0]  page;
  logic [15:0] boot;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hresp, er, wst, lk;
  logic [7:0]  lkd;
  int          n_er = 0;
  int          n_wr = 0;
  int          n_lk = 0;
  int          errors = 0;
  int          n_checks = 0;
  self_program_ctrl #(.PROG_CYCLES(20)) dut_u (
    .CLK(clk), .RESET(reset), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
    .BOOT_SIZE_FUSE_HI(fz_hi), .BOOT_SIZE_FUSE_LO(fz_lo),
    .EEPROM_WRITE_BUSY(ee_busy), .FETCH_ADDR(fetch),
    .FETCH_ALLOW(allow), .CPU_HALT(halt), .REGION_BUSY_FLAG(busy),
    .FLASH_ERASE_START(er), .FLASH_WRITE_START(wst), .LOCK_WRITE_START(lk),
    .FLASH_PAGE(page), .LOCK_DATA(lkd), .BOOT_RESET_ADDR(boot), .IRQ(irq));
  cpu_core_model cpu_u (
    .clk(clk), .hreadyout(hready), .hrdata(hrdata), .ee_busy(ee_busy),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  initial forever #10 clk = ~clk;
  // Start pulses last one cycle; count them rather than chase them
  always @(posedge clk) begin
    if (er === 1'b1) n_er++;
    if (wst === 1'b1) n_wr++;
    if (lk === 1'b1) n_lk++;
  end
  // ==========================================================================
  // Checking and bus helpers
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    cpu_u.bus(1'b1, cpu_u.ad(i), d, q);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] q);
    cpu_u.bus(1'b0, cpu_u.ad(i), 32'h0, q);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_window();
    logic [31:0] q;
    rd(spm_pkg::IDX_CTRL_STATUS, q);
    chk("ctrl reset", q, 32'h0);
    wr(spm_pkg::IDX_CTRL_STATUS, 32'h03);
    repeat (6) @(posedge clk);
    rd(spm_pkg::IDX_CTRL_STATUS, q);
    chk("ctrl expired", q, 32'h0);
    rd(spm_pkg::IDX_IRQ_STATUS, q);
    chk("ev expired", q, 32'h2);
    wr(spm_pkg::IDX_IRQ_ENABLE, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq on", 32'(irq), 32'h1);
    wr(spm_pkg::IDX_IRQ_CLEAR, 32'h7);
    repeat (3) @(posedge clk);
    chk("irq off", 32'(irq), 32'h0);
    wr(spm_pkg::IDX_Z_POINTER, 32'h1);
    cpu_u.spm(8'h03);
    rd(spm_pkg::IDX_IRQ_STATUS, q);
    chk("ev refused", q, 32'h4);
    wr(spm_pkg::IDX_IRQ_CLEAR, 32'h7);
    wr(spm_pkg::IDX_Z_POINTER, 32'h0);
    ee_busy <= 1'b1;
    wr(spm_pkg::IDX_CTRL_STATUS, 32'h03);
    wr(spm_pkg::IDX_SPM_STROBE, 32'h1);
    ee_busy <= 1'b0;
    rd(spm_pkg::IDX_IRQ_STATUS, q);
    chk("ev eeprom", q, 32'h4);
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  task automatic t_erase();
    wr(spm_pkg::IDX_Z_POINTER, 32'h3800);
    cpu_u.spm(8'h03);
    repeat (3) @(posedge clk);
    chk("halt", 32'(halt), 32'h1);
    chk("busy halt pg", 32'(busy), 32'h0);
    wr(spm_pkg::IDX_Z_POINTER, 32'h80);
    cpu_u.spm(8'h03);
    fetch <= 16'h0;
    repeat (3) @(posedge clk);
    chk("page", 32'(page), 32'h1);
    chk("busy set", 32'(busy), 32'h1);
    chk("allow", 32'(allow), 32'h0);
    cpu_u.spm(8'h11);
    repeat (3) @(posedge clk);
    chk("busy clear", 32'(busy), 32'h0);
  endtask
  task automatic t_fill();
    logic [31:0] q;
    wr(spm_pkg::IDX_Z_POINTER, 32'h8a);
    wr(spm_pkg::IDX_DATA_WORD, 32'h1234);
    cpu_u.spm(8'h01);
    rd(spm_pkg::IDX_BUF_DATA, q);
    chk("buffer", q, 32'h1234);
    rd(spm_pkg::IDX_Z_INFO, q);
    chk("zinfo13", q, 32'hc5010040);
    wr(spm_pkg::IDX_CONFIG, 32'h1);
    wr(spm_pkg::IDX_Z_POINTER, 32'h400a);
    cpu_u.spm(8'h11);
    rd(spm_pkg::IDX_Z_INFO, q);
    chk("zinfo14", q, 32'h45802000);
    wr(spm_pkg::IDX_Z_POINTER, 32'h4000);
    cpu_u.spm(8'h05);
    repeat (2) @(posedge clk);
    chk("page14", 32'(page), 32'h80);
    wr(spm_pkg::IDX_DATA_WORD, 32'h00a5);
    cpu_u.spm(8'h09);
    repeat (2) @(posedge clk);
    chk("lock data", 32'(lkd), 32'ha5);
    chk("erase starts", n_er, 2);
    chk("write starts", n_wr, 1);
    chk("lock starts", n_lk, 1);
  endtask
  task automatic t_boot();
    logic [31:0] q;
    logic [15:0] sz;
    logic [15:0] st;
    for (int i = 0; i < 8; i++) begin
      wr(spm_pkg::IDX_CONFIG, 32'(i / 4));
      {fz_hi, fz_lo} <= 2'(i);
      repeat (5) @(posedge clk);
      sz = (i < 4 ? 16'h400 : 16'h800) >> (i % 4);
      st = (i < 4 ? 16'h2000 : 16'h4000) - sz;
      rd(spm_pkg::IDX_BOOT_INFO, q);
      chk("boot info", q, {sz, st});
      chk("boot addr", 32'(boot), 32'(st));
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_window();
    t_erase();
    t_fill();
    t_boot();
    complete_run();
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule
